// ===== hw/uubc_top.sv
// serial bridge controller: buffers, baud generator, framer, aux pins
//
// Overview of operation
// R01: sampling ticks come from a 120 MHz reference, sixteen or ten per bit.
// R02: divider is a 14-bit integer plus a 4-bit sixteenths fraction.
// R03: accepted rates lie between 183 baud and 12 Mbaud; the 14-bit divider integer keeps the code at or above about 458 baud.
// R04: settings giving 7, 9, 10 or 11 Mbaud are refused as invalid.
// R05: receive data is flushed after a 0-255 ms timeout, 16 ms by default.
// R06: host bytes wait in a 1 Kbyte transmit buffer, sent in order.
// R07: received bytes wait in a 1 Kbyte buffer until the host reads them.
// R08: RS485 drive enable is high only while a character shifts out.
// R09: power allow output follows the bus suspend state.
// R10: power allow is high while suspended and low in normal operation.
// R11: transmit indicator pin gives an active-low pulse on each sent byte.
// R12: receive indicator pin gives an active-low pulse on each received byte.
// R13: traffic indicator pin pulses low on either transmit or receive.
// R14: sleep indicator pin goes low while the bus is suspended.
// R15: a pin may output a 30, 15 or 7.5 MHz divided clock.
// R16: a pin may be pulled-up unused input, constant high or constant low.
// R17: each aux pin has eleven functions loaded from nonvolatile memory.
// R18: aux pins work as general-purpose I/O alongside serial operation.
// R19: logic resets at power-up and on the external active-low reset.
// R20: serial mode is the default unless nonvolatile memory picks another.
// R21: the host may change the interface mode at run time.
// R22: frames are low start, eight data bits LSB first, high stop.
`default_nettype none
module uubc_top #(
	parameter int MS_CYCLES = uubc_pkg::MS_CYC_DEF
) (
	// clock and resets
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ext_rst_n_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// serial line and transceiver control
	input wire logic uart_rxd_in,
	output logic uart_txd_out,
	output logic rs485_drive_enable_out,
	output logic power_allow_n_out,
	output logic flush_out,
	// bus state and nonvolatile configuration
	input wire logic suspend_in,
	input wire logic nvm_present_in,
	input wire uubc_pkg::uubc_mode_type nvm_mode_in,
	input wire logic [15:0] nvm_aux_cfg_in,
	// auxiliary pins
	input wire logic [3:0] aux_pin_bus_in,
	output logic [3:0] aux_pin_bus_out,
	output logic [3:0] aux_pin_bus_oe_out
);
	import uubc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [10:0] txw, txr, rxw, rxr;
		logic [13:0] b_int;
		logic [3:0] b_frac;
		logic b_x10;
		logic [7:0] tmo;
		logic [1:0] clk_sel;
		logic [3:0] gpio_o;
		uubc_mode_type mode;
		logic [15:0] aux_cfg;
		logic loaded;
		logic [4:0] flags;
		logic [4:0] ref_acc;
		logic [3:0] ref_cnt;
		logic [17:0] div_acc;
		uubc_ser_type tx_st;
		logic [3:0] tx_tk;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		uubc_ser_type rx_st;
		logic [3:0] rx_tk;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [17:0] ms_cnt;
		logic [7:0] to_cnt;
		logic [7:0] tx_indicator_n, rx_indicator_n;
		logic txd, de, pwr_n, flush;
		logic [3:0] aux_o, aux_oe;
	} uubc_state_type;

	uubc_state_type st_reg, st_next;
	logic [7:0] tx_mem [0:1023];
	logic [7:0] rx_mem [0:1023];
	logic rst, req, tx_push, rx_push, rx_pop;
	logic [31:0] wv;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lanes(input logic [3:0] sel);
		lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lanes

	function automatic logic [10:0] used(input logic [10:0] w, r);
		used = w - r;
	endfunction : used

	// product of ticks per bit and divisor in sixteenths
	function automatic logic baud_ok(input logic [13:0] bi,
		input logic [3:0] bf, input logic x10);
		logic [23:0] p;
		logic [17:0] d;
		d = {bi, bf};
		p = 24'(d) * 24'(x10 ? OS10 : OS16);
		baud_ok = (d >= 18'(FRAC_ONE)) && p >= P_MIN && p <= P_MAX
			&& !(p >= B7_LO && p <= B7_HI)
			&& !(p >= B9_LO && p <= B9_HI); // see R03 see R04
	endfunction : baud_ok

	function automatic logic [3:0] last_tk(input logic x10);
		last_tk = x10 ? LAST10 : LAST16; // see R01
	endfunction : last_tk

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic samp, ms_tick, rtick, act, ovf;
		logic [18:0] acc;
		logic [5:0] radd;
		logic [4:0] fset, fclr;
		logic [3:0] code;
		st_next = st_reg;
		samp = 1'b0;
		ms_tick = 1'b0;
		rtick = 1'b0;
		act = 1'b0;
		ovf = 1'b0;
		acc = '0;
		radd = '0;
		fset = '0;
		fclr = '0;
		code = '0;
		tx_push = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		req = wb_cyc_in && wb_stb_in && !st_reg.ack;
		wv = '0;
		// configuration straps are taken once after reset
		if (!st_reg.loaded) begin
			st_next.loaded = 1'b1;
			st_next.aux_cfg = nvm_aux_cfg_in; // see R17
			st_next.mode = nvm_present_in ? nvm_mode_in : MODE_UART; // see R20
		end
		// ------------------------ bus slave ------------------------
		st_next.ack = req;
		st_next.dat = '0;
		if (req) begin
			case (wb_adr_in)
				A_DATA: begin
					if (!wb_we_in && st_reg.rxw != st_reg.rxr) begin
						st_next.dat = {23'h000000, 1'b1,
							rx_mem[st_reg.rxr[9:0]]};
						rx_pop = 1'b1; // see R07
					end
					if (wb_we_in && wb_sel_in[0]) begin
						if (used(st_reg.txw, st_reg.txr) == 11'h400)
							fset[F_TXOVF] = 1'b1;
						else
							tx_push = 1'b1; // see R06
					end
				end
				A_STAT: st_next.dat = {st_reg.tx_st != S_IDLE,
					st_reg.rx_st != S_IDLE, 3'h0,
					used(st_reg.rxw, st_reg.rxr), 5'h00,
					used(st_reg.txw, st_reg.txr)};
				A_BAUD: begin
					wv = {13'h0000, st_reg.b_x10, st_reg.b_frac, st_reg.b_int};
					st_next.dat = wv;
					if (wb_we_in) begin
						wv = (wv & ~lanes(wb_sel_in))
							| (wb_dat_in & lanes(wb_sel_in));
						if (baud_ok(wv[13:0], wv[17:14], wv[18])) begin
							st_next.b_int = wv[13:0]; // see R02
							st_next.b_frac = wv[17:14];
							st_next.b_x10 = wv[18];
						end else begin
							fset[F_BAUD] = 1'b1; // see R04
						end
					end
				end
				A_TMO: begin
					st_next.dat = {24'h000000, st_reg.tmo};
					if (wb_we_in && wb_sel_in[0])
						st_next.tmo = wb_dat_in[7:0]; // see R05
				end
				A_AUX: begin
					st_next.dat = {14'h0000, st_reg.clk_sel, st_reg.aux_cfg};
					if (wb_we_in && wb_sel_in[2])
						st_next.clk_sel = wb_dat_in[17:16];
				end
				A_GPIO: begin
					st_next.dat = {24'h000000, aux_pin_bus_in, st_reg.gpio_o};
					if (wb_we_in && wb_sel_in[0])
						st_next.gpio_o = wb_dat_in[3:0]; // see R18
				end
				A_MODE: begin
					st_next.dat = {30'h00000000, st_reg.mode};
					if (wb_we_in && wb_sel_in[0])
						st_next.mode = uubc_mode_type'(wb_dat_in[1:0]); // see R21
				end
				A_FLAG: begin
					st_next.dat = {27'h0000000, st_reg.flags};
					if (wb_we_in && wb_sel_in[0])
						fclr = wb_dat_in[4:0];
				end
				default: st_next.dat = '0;
			endcase
		end
		if (tx_push)
			st_next.txw = st_reg.txw + 11'h001;
		if (rx_pop)
			st_next.rxr = st_reg.rxr + 11'h001;
		// ------------------------ baud ticks -----------------------
		// one spare bit: 24 + 12 would wrap in five bits and lose a tick
		radd = {1'b0, st_reg.ref_acc} + {1'b0, REF_STEP};
		if (radd >= {1'b0, REF_MOD}) begin
			rtick = 1'b1;
			radd = radd - {1'b0, REF_MOD};
		end
		st_next.ref_acc = radd[4:0];
		if (rtick) begin
			st_next.ref_cnt = st_reg.ref_cnt + 4'h1;
			acc = 19'(st_reg.div_acc) + FRAC_ONE; // see R01 see R02
			if (acc >= 19'({st_reg.b_int, st_reg.b_frac})) begin
				acc = acc - 19'({st_reg.b_int, st_reg.b_frac});
				samp = 1'b1;
			end
			st_next.div_acc = acc[17:0];
		end
		act = st_reg.mode == MODE_UART;
		// ------------------------ transmitter ----------------------
		if (samp) begin
			st_next.tx_tk = st_reg.tx_tk + 4'h1;
			case (st_reg.tx_st)
				S_IDLE: begin
					st_next.tx_tk = '0;
					if (act && st_reg.txw != st_reg.txr) begin
						st_next.tx_sh = tx_mem[st_reg.txr[9:0]]; // see R06
						st_next.txr = st_reg.txr + 11'h001;
						st_next.tx_st = S_START;
						st_next.tx_indicator_n = LED_PULSE_CYC; // see R11
					end
				end
				S_START: if (st_reg.tx_tk == last_tk(st_reg.b_x10)) begin
					st_next.tx_tk = '0;
					st_next.tx_bit = '0;
					st_next.tx_st = S_DATA;
				end
				S_DATA: if (st_reg.tx_tk == last_tk(st_reg.b_x10)) begin
					st_next.tx_tk = '0;
					st_next.tx_sh = {1'b0, st_reg.tx_sh[7:1]}; // see R22
					st_next.tx_bit = st_reg.tx_bit + 3'h1;
					if (st_reg.tx_bit == 3'h7)
						st_next.tx_st = S_STOP;
				end
				S_STOP: if (st_reg.tx_tk == last_tk(st_reg.b_x10)) begin
					st_next.tx_tk = '0;
					st_next.tx_st = S_IDLE;
				end
				default: st_next.tx_st = S_IDLE;
			endcase
		end
		// ------------------------ receiver -------------------------
		if (samp) begin
			st_next.rx_tk = st_reg.rx_tk + 4'h1;
			case (st_reg.rx_st)
				S_IDLE: begin
					st_next.rx_tk = '0;
					if (act && !uart_rxd_in)
						st_next.rx_st = S_START;
				end
				S_START: if (st_reg.rx_tk ==
					(st_reg.b_x10 ? HALF10 : HALF16)) begin
					st_next.rx_tk = '0;
					st_next.rx_bit = '0;
					st_next.rx_st = uart_rxd_in ? S_IDLE : S_DATA;
				end
				S_DATA: if (st_reg.rx_tk == last_tk(st_reg.b_x10)) begin
					st_next.rx_tk = '0;
					st_next.rx_sh = {uart_rxd_in, st_reg.rx_sh[7:1]}; // see R22
					st_next.rx_bit = st_reg.rx_bit + 3'h1;
					if (st_reg.rx_bit == 3'h7)
						st_next.rx_st = S_STOP;
				end
				S_STOP: if (st_reg.rx_tk == last_tk(st_reg.b_x10)) begin
					st_next.rx_st = S_IDLE;
					ovf = used(st_reg.rxw, st_reg.rxr) == 11'h400;
					if (!uart_rxd_in)
						fset[F_FRAME] = 1'b1;
					else if (ovf)
						fset[F_RXOVR] = 1'b1;
					else
						rx_push = 1'b1; // see R07
				end
				default: st_next.rx_st = S_IDLE;
			endcase
		end
		if (rx_push) begin
			st_next.rxw = st_reg.rxw + 11'h001;
			st_next.rx_indicator_n = LED_PULSE_CYC; // see R12
		end
		if (st_reg.tx_indicator_n != 8'h00 && st_next.tx_indicator_n == st_reg.tx_indicator_n)
			st_next.tx_indicator_n = st_reg.tx_indicator_n - 8'h01;
		if (st_reg.rx_indicator_n != 8'h00 && !rx_push)
			st_next.rx_indicator_n = st_reg.rx_indicator_n - 8'h01;
		// ------------------------ flush timeout --------------------
		st_next.flush = 1'b0;
		st_next.ms_cnt = st_reg.ms_cnt + 18'h00001;
		if (st_reg.ms_cnt == 18'(MS_CYCLES - 1)) begin
			st_next.ms_cnt = '0;
			ms_tick = 1'b1;
		end
		if (rx_push || st_reg.rxw == st_reg.rxr) begin
			st_next.to_cnt = '0;
		end else if (ms_tick) begin
			st_next.to_cnt = st_reg.to_cnt + 8'h01;
			if (st_reg.to_cnt >= st_reg.tmo) begin
				st_next.to_cnt = '0;
				st_next.flush = 1'b1; // see R05
				fset[F_FLUSH] = 1'b1;
			end
		end
		// event set wins over a software clear in the same cycle
		st_next.flags = (st_reg.flags & ~fclr) | fset;
		// ------------------------ pins -----------------------------
		case (st_next.tx_st)
			S_START: st_next.txd = 1'b0; // see R22
			S_DATA: st_next.txd = st_next.tx_sh[0];
			default: st_next.txd = 1'b1;
		endcase
		st_next.de = st_next.tx_st != S_IDLE; // see R08
		st_next.pwr_n = suspend_in; // see R09 see R10
		for (int i = 0; i < 4; i++) begin
			code = st_next.aux_cfg[4*i +: 4];
			st_next.aux_oe[i] = 1'b1;
			case (code)
				AUX_DE: st_next.aux_o[i] = st_next.de;
				AUX_PWR: st_next.aux_o[i] = st_next.pwr_n;
				AUX_TXI: st_next.aux_o[i] = st_next.tx_indicator_n == 8'h00; // see R11
				AUX_RXI: st_next.aux_o[i] = st_next.rx_indicator_n == 8'h00; // see R12
				AUX_TRF: st_next.aux_o[i] = (st_next.tx_indicator_n
					| st_next.rx_indicator_n) == 8'h00; // see R13
				AUX_SLP: st_next.aux_o[i] = !suspend_in; // see R14
				AUX_CLK: case (st_next.clk_sel)
					2'b00: st_next.aux_o[i] = st_next.ref_cnt[1]; // see R15
					2'b01: st_next.aux_o[i] = st_next.ref_cnt[2];
					default: st_next.aux_o[i] = st_next.ref_cnt[3];
				endcase
				AUX_HI: st_next.aux_o[i] = 1'b1; // see R16
				AUX_LO: st_next.aux_o[i] = 1'b0;
				AUX_GPIO: st_next.aux_o[i] = st_next.gpio_o[i]; // see R18
				default: begin
					// pulled-up unused input, also for spare codes
					st_next.aux_o[i] = 1'b0;
					st_next.aux_oe[i] = 1'b0; // see R16
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers and buffer memories
	// ---------------------------------------------------------------
	assign rst = sys_rst_in || !ext_rst_n_in; // see R19

	always_ff @(posedge clk_in) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.b_int <= BAUD_INT_RST;
			st_reg.b_frac <= BAUD_FRAC_RST;
			st_reg.tmo <= TMO_RST; // see R05
			st_reg.txd <= 1'b1;
			st_reg.pwr_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (tx_push)
			tx_mem[st_reg.txw[9:0]] <= wb_dat_in[7:0];
		if (rx_push)
			rx_mem[st_reg.rxw[9:0]] <= st_next.rx_sh;
	end

	assign wb_dat_out = st_reg.dat;
	assign wb_ack_out = st_reg.ack;
	assign uart_txd_out = st_reg.txd;
	assign rs485_drive_enable_out = st_reg.de;
	assign power_allow_n_out = st_reg.pwr_n;
	assign flush_out = st_reg.flush;
	assign aux_pin_bus_out = st_reg.aux_o;
	assign aux_pin_bus_oe_out = st_reg.aux_oe;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_de_follows_tx: assert property (@(posedge clk_in) disable iff (rst) // see R08
		rs485_drive_enable_out == (st_reg.tx_st != S_IDLE))
		else $error("drive enable does not match transmitter");
	a_power_suspend: assert property (@(posedge clk_in) disable iff (rst) // see R10
		!$past(rst) |-> power_allow_n_out == $past(suspend_in))
		else $error("power allow does not follow suspend");
	a_start_bit_low: assert property (@(posedge clk_in) disable iff (rst) // see R22
		(st_reg.tx_st == S_START) |-> !uart_txd_out)
		else $error("start bit not low");
	a_line_idle_high: assert property (@(posedge clk_in) disable iff (rst) // see R22
		(st_reg.tx_st inside {S_IDLE, S_STOP}) |-> uart_txd_out)
		else $error("line not high when idle or stop");
	a_baud_refused: assert property (@(posedge clk_in) disable iff (rst) // see R04
		(req && wb_we_in && wb_adr_in == A_BAUD
		&& !baud_ok(wv[13:0], wv[17:14], wv[18]))
		|=> $stable(st_reg.b_int) && st_reg.flags[F_BAUD])
		else $error("invalid baud setting accepted");
	a_tmo_default: assert property (@(posedge clk_in) // see R05
		$fell(rst) |-> st_reg.tmo == TMO_RST)
		else $error("timeout default wrong");
	a_rx_held: assert property (@(posedge clk_in) disable iff (rst) // see R07
		!(req && !wb_we_in && wb_adr_in == A_DATA) |=> $stable(st_reg.rxr))
		else $error("receive byte released without host read");
	a_ack_single: assert property (@(posedge clk_in) disable iff (rst)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	a_tx_in_order: assert property (@(posedge clk_in) disable iff (rst) // see R06
		(st_reg.txr != $past(st_reg.txr)) |->
		st_reg.tx_st == S_START && st_reg.txr == $past(st_reg.txr) + 11'h001)
		else $error("transmit buffer drained out of order");
	a_aux_drive_low: assert property (@(posedge clk_in) disable iff (rst) // see R16
		(st_reg.aux_cfg[11:8] == AUX_LO) |->
		!aux_pin_bus_out[2] && aux_pin_bus_oe_out[2])
		else $error("drive-low pin not driven low");
endmodule : uubc_top
`default_nettype wire

// ===== hw/uubc_pkg.sv
// constants, register map and types for the serial bridge controller
`default_nettype none
package uubc_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int LED_PULSE_NS = 1000;
	localparam logic [7:0] LED_PULSE_CYC = 8'(LED_PULSE_NS / CLK_PERIOD_NS);
	// 120 MHz reference ticks made from the 250 MHz clock: 12 of 25
	localparam logic [4:0] REF_STEP = 5'h0c;
	localparam logic [4:0] REF_MOD = 5'h19;
	localparam logic [18:0] FRAC_ONE = 19'h00010;
	localparam logic [3:0] LAST16 = 4'hf;
	localparam logic [3:0] LAST10 = 4'h9;
	localparam logic [3:0] HALF16 = 4'h7;
	localparam logic [3:0] HALF10 = 4'h4;
	localparam logic [4:0] OS16 = 5'h10;
	localparam logic [4:0] OS10 = 5'h0a;
	// ticks-times-divisor products: 12 Mbaud top, 183 baud bottom
	localparam logic [23:0] P_MIN = 24'h0000a0;
	localparam logic [23:0] P_MAX = 24'ha0179b;
	localparam logic [23:0] B7_LO = 24'h000101;
	localparam logic [23:0] B7_HI = 24'h000127;
	localparam logic [23:0] B9_LO = 24'h0000a8;
	localparam logic [23:0] B9_HI = 24'h0000e1;
	// ---------------------------------------------------------------
	// register map and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] A_DATA = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_BAUD = 8'h08;
	localparam logic [7:0] A_TMO = 8'h0c;
	localparam logic [7:0] A_AUX = 8'h10;
	localparam logic [7:0] A_GPIO = 8'h14;
	localparam logic [7:0] A_MODE = 8'h18;
	localparam logic [7:0] A_FLAG = 8'h1c;
	localparam logic [13:0] BAUD_INT_RST = 14'h030d;
	localparam logic [3:0] BAUD_FRAC_RST = 4'h4;
	localparam logic [7:0] TMO_RST = 8'h10;
	localparam int F_TXOVF = 0;
	localparam int F_RXOVR = 1;
	localparam int F_FRAME = 2;
	localparam int F_BAUD = 3;
	localparam int F_FLUSH = 4;
	// ---------------------------------------------------------------
	// auxiliary pin function codes
	// ---------------------------------------------------------------
	localparam logic [3:0] AUX_DE = 4'h0;
	localparam logic [3:0] AUX_PWR = 4'h1;
	localparam logic [3:0] AUX_TXI = 4'h2;
	localparam logic [3:0] AUX_RXI = 4'h3;
	localparam logic [3:0] AUX_TRF = 4'h4;
	localparam logic [3:0] AUX_SLP = 4'h5;
	localparam logic [3:0] AUX_CLK = 4'h6;
	localparam logic [3:0] AUX_PU = 4'h7;
	localparam logic [3:0] AUX_HI = 4'h8;
	localparam logic [3:0] AUX_LO = 4'h9;
	localparam logic [3:0] AUX_GPIO = 4'ha;
	typedef enum logic [1:0] {
		MODE_UART = 2'b00, MODE_FIFO = 2'b01,
		MODE_FSER = 2'b10, MODE_BANG = 2'b11
	} uubc_mode_type;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00, S_START = 2'b01, S_DATA = 2'b10, S_STOP = 2'b11
	} uubc_ser_type;
endpackage : uubc_pkg
`default_nettype wire

// ===== verif/uubc_line.sv
// line transceiver model: decodes txd frames, sends rxd frames
`default_nettype none
module uubc_line #(
	parameter int BIT = 133
) (
	// clock
	input wire logic clk_in,
	// serial line
	input wire logic txd_in,
	output var logic rxd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	logic [7:0] b;
	int errs = 0;
	initial rxd_out = 1'b1;
	// ---------------------------------------------------------------
	// receiver: samples each bit in its middle
	// ---------------------------------------------------------------
	initial begin
		forever begin
			@(negedge txd_in);
			repeat (BIT / 2) @(posedge clk_in);
			if (txd_in === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(posedge clk_in);
					b[i] = txd_in;
				end
				repeat (BIT) @(posedge clk_in);
				if (txd_in !== 1'b1) errs++;
				rx_q.push_back(b);
			end
		end
	end
	// ---------------------------------------------------------------
	// transmitter: start low, lsb first, stop high, idle high
	// ---------------------------------------------------------------
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_out <= f[i];
			repeat (BIT) @(posedge clk_in);
		end
	endtask : send
endmodule : uubc_line
`default_nettype wire

// ===== verif/usb_uart_bridge_controller_bench.sv
// self-checking bench for the serial bridge controller
`default_nettype none
module usb_uart_bridge_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import uubc_pkg::*;
	logic clk_in = 1'b0;
	logic rst = 1'b1;
	logic rst_n = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic susp = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, txd, rxd, de, pwr_n, flush, s0, s1;
	logic [15:0] cfg = 16'h298a;
	logic [3:0] pin_in = 4'h6;
	logic [3:0] sel = 4'h0;
	logic [3:0] bsel = 4'hf;
	logic nvm_p = 1'b1;
	uubc_mode_type nvm_m = MODE_FIFO;
	logic [3:0] pin_out, pin_oe;
	int mismatches = 0;
	int n_checks = 0;
	always #2 clk_in = ~clk_in;
	// short ms so the flush timeout fits the run
	uubc_top #(.MS_CYCLES(50)) u_dut (
		.clk_in(clk_in), .sys_rst_in(rst), .ext_rst_n_in(rst_n),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack),
		.uart_rxd_in(rxd), .uart_txd_out(txd),
		.rs485_drive_enable_out(de), .power_allow_n_out(pwr_n),
		.flush_out(flush), .suspend_in(susp), .nvm_present_in(nvm_p),
		.nvm_mode_in(nvm_m), .nvm_aux_cfg_in(cfg),
		.aux_pin_bus_in(pin_in), .aux_pin_bus_out(pin_out),
		.aux_pin_bus_oe_out(pin_oe)
	);
	// divisor 4.0 x16 gives 133.3 clocks per bit
	uubc_line #(.BIT(133)) u_line (
		.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd)
	);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// call just after a rising edge; leaves the bus idle one edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= bsel;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		if (n >= 40) mismatches++;
		@(posedge clk_in);
	endtask : wb
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rc
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		rst <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("pwr_n", 32'(pwr_n), 32'h0);
		rc(A_BAUD, 32'h0001030d, "baud");
		rc(A_TMO, 32'h10, "tmo");
		rc(A_MODE, 32'h1, "mode");
		rc(8'h20, 32'h0, "unmapped");
		rc(A_AUX, 32'h298a, "aux");
		$display("test reset done");
		wb(1'b1, A_MODE, 32'h2);
		rc(A_MODE, 32'h2, "mode");
		wb(1'b1, A_MODE, 32'h0);
		wb(1'b1, A_BAUD, 32'h4);
		rc(A_BAUD, 32'h4, "baud");
		bsel = 4'h1;
		wb(1'b1, A_BAUD, 32'h00050008);
		bsel = 4'hf;
		rc(A_BAUD, 32'h8, "baud lanes");
		wb(1'b1, A_BAUD, 32'h00040001);
		rc(A_BAUD, 32'h00040001, "baud top");
		wb(1'b1, A_BAUD, 32'h00050001);
		rc(A_BAUD, 32'h00040001, "baud");
		rc(A_FLAG, 32'h8, "flags");
		wb(1'b1, A_FLAG, 32'h1f);
		rc(A_FLAG, 32'h0, "flags");
		wb(1'b1, A_BAUD, 32'h4);
		$display("test baud done");
		wb(1'b1, A_GPIO, 32'h1);
		rc(A_GPIO, 32'h61, "gpio");
		chk("pins", 32'({de, pin_oe[2:1], pin_out}), 32'h3b);
		s0 = 1'b0;
		s1 = 1'b0;
		wb(1'b1, A_DATA, 32'ha5);
		wb(1'b1, A_DATA, 32'h3c);
		for (int i = 0; i < 4000 && u_line.rx_q.size() < 2; i++) begin
			@(posedge clk_in);
			if (de === 1'b1) s0 = 1'b1;
			if (pin_out[3] === 1'b0) s1 = 1'b1;
		end
		chk("tx count", 32'(u_line.rx_q.size()), 32'h2);
		chk("byte0", 32'(u_line.rx_q[0]), 32'ha5);
		chk("byte1", 32'(u_line.rx_q[1]), 32'h3c);
		chk("frame errs", 32'(u_line.errs), 32'h0);
		chk("de txi", 32'({s0, s1}), 32'h3);
		repeat (200) @(posedge clk_in);
		chk("de idle", 32'(de), 32'h0);
		$display("test transmit done");
		u_line.send(8'h5a);
		repeat (2) @(posedge clk_in);
		rc(A_STAT, 32'h00010000, "stat");
		rc(A_DATA, 32'h15a, "rx");
		rc(A_DATA, 32'h0, "rx empty");
		$display("test receive done");
		wb(1'b1, A_TMO, 32'h2);
		s0 = 1'b0;
		fork
			u_line.send(8'h11);
			for (int i = 0; i < 1800; i++) begin
				@(posedge clk_in);
				if (flush === 1'b1) s0 = 1'b1;
			end
		join
		chk("flush", 32'(s0), 32'h1);
		rc(A_FLAG, 32'h10, "flags");
		rc(A_DATA, 32'h111, "rx");
		susp <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("pwr_n", 32'(pwr_n), 32'h1);
		susp <= 1'b0;
		$display("test flush done");
		cfg <= 16'h7543;
		nvm_p <= 1'b0;
		nvm_m <= MODE_BANG;
		pin_in <= 4'h9;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_in);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_in);
		rc(A_BAUD, 32'h0001030d, "baud");
		rc(A_MODE, 32'h0, "mode");
		rc(A_GPIO, 32'h90, "gpio");
		chk("pins2", 32'({pin_oe[3], pin_out[2:0]}), 32'h7);
		wb(1'b1, A_BAUD, 32'h4);
		s0 = 1'b0;
		s1 = 1'b0;
		fork
			u_line.send(8'h81);
			for (int i = 0; i < 1600; i++) begin
				@(posedge clk_in);
				if (pin_out[0] === 1'b0) s0 = 1'b1;
				if (pin_out[1] === 1'b0) s1 = 1'b1;
			end
		join
		chk("rxi trf", 32'({s0, s1}), 32'h3);
		susp <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("sleep", 32'(pin_out[2]), 32'h0);
		$display("test aux done");
		end_sim();
	end
	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge clk_in);
		$display("watchdog expired");
		mismatches++;
		end_sim();
	end
endmodule : usb_uart_bridge_controller_bench
`default_nettype wire
